// >>> common/csb_link_if.sv
// interface: sideband wires between module end and bridge end
`timescale 1ns/1ps
interface csb_link_if;
   logic fp_error_n_oe;
   logic ignore_numeric_error_n_oe;
   logic cpu_init_n_oe;
   logic cpu_irq_request_oe;
   logic nmi_request_oe;
   logic addr20_mask_n_oe;
   logic sys_mgmt_irq_n_oe;
   logic stop_clock_req_n_oe;
   logic suspend_status_n;
   logic regulator_enable;
   logic regulator_power_good;
   logic bridge_power_ok;
   logic pci_reset_n;
   logic thermal_alert_n_oe;
   logic smbus_clock_oe_dev;
   logic smbus_clock_oe_host;
   logic smbus_data_oe_dev;
   logic smbus_data_oe_host;
   // open-drain wire levels: low while anybody pulls
   logic fp_error_n;
   logic ignore_numeric_error_n;
   logic cpu_init_n;
   logic cpu_irq_request;
   logic nmi_request;
   logic addr20_mask_n;
   logic sys_mgmt_irq_n;
   logic stop_clock_req_n;
   logic thermal_alert_n;
   logic smbus_clock_line;
   logic smbus_data_line;
   assign fp_error_n             = ~fp_error_n_oe;
   assign ignore_numeric_error_n = ~ignore_numeric_error_n_oe;
   assign cpu_init_n             = ~cpu_init_n_oe;
   assign cpu_irq_request        = ~cpu_irq_request_oe;
   assign nmi_request            = ~nmi_request_oe;
   assign addr20_mask_n          = ~addr20_mask_n_oe;
   assign sys_mgmt_irq_n         = ~sys_mgmt_irq_n_oe;
   assign stop_clock_req_n       = ~stop_clock_req_n_oe;
   assign thermal_alert_n        = ~thermal_alert_n_oe;
   assign smbus_clock_line       = ~(smbus_clock_oe_dev | smbus_clock_oe_host);
   assign smbus_data_line        = ~(smbus_data_oe_dev | smbus_data_oe_host);
   modport dev (
      output fp_error_n_oe, thermal_alert_n_oe, regulator_power_good,
      output smbus_clock_oe_dev, smbus_data_oe_dev,
      input  ignore_numeric_error_n, cpu_init_n, cpu_irq_request, nmi_request,
      input  addr20_mask_n, sys_mgmt_irq_n, stop_clock_req_n, suspend_status_n,
      input  regulator_enable, bridge_power_ok, pci_reset_n,
      input  smbus_clock_line, smbus_data_line
   );
   modport host (
      output ignore_numeric_error_n_oe, cpu_init_n_oe, cpu_irq_request_oe, nmi_request_oe,
      output addr20_mask_n_oe, sys_mgmt_irq_n_oe, stop_clock_req_n_oe,
      output suspend_status_n, regulator_enable, bridge_power_ok, pci_reset_n,
      output smbus_clock_oe_host, smbus_data_oe_host,
      input  fp_error_n, thermal_alert_n, regulator_power_good,
      input  smbus_clock_line, smbus_data_line
   );
endinterface

// >>> common/csb_pkg.sv
// package: shared constants for the sideband and power signalling ends
package csb_pkg;
   localparam int unsigned CLK_PERIOD_NS   = 10;
   localparam int unsigned PWROK_MIN_MS    = 1;
   localparam int unsigned PWROK_CYCLES    = (PWROK_MIN_MS * 1000000) / CLK_PERIOD_NS;
   localparam int unsigned VR_SETTLE_NS    = 1000;
   localparam int unsigned VR_SETTLE_CYC   = VR_SETTLE_NS / CLK_PERIOD_NS;
   localparam int unsigned CNT_W           = 24;
   localparam int unsigned ADDR_W          = 32;
   localparam int unsigned ADDR20_BIT      = 20;
   localparam logic [6:0]  THERM_SMB_ADDR  = 7'h4c;
   localparam logic [7:0]  THERM_CFG_RESET = 8'h00;
   typedef enum logic [1:0] {CSB_RUN, CSB_QSTART} csb_cpu_state_type;
   typedef enum logic [1:0] {CSB_PWR_OFF, CSB_PWR_WAIT_OK, CSB_PWR_WAIT_RST, CSB_PWR_ON}
      csb_pwr_state_type;
endpackage

// >>> design/csb_bridge_end.sv
// bridge end: sideband drivers and power sequencing toward the module
`timescale 1ns/1ps
module csb_bridge_end #(
   parameter int unsigned PWROK_CYC = csb_pkg::PWROK_CYCLES
) (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic clk_en,
   csb_link_if.host  link,
   input  wire logic ignore_error_req,
   input  wire logic init_req,
   input  wire logic irq_req,
   input  wire logic serr_n,
   input  wire logic io_channel_check_n,
   input  wire logic nmi_on_serr_en,
   input  wire logic nmi_on_chan_chk_en,
   input  wire logic a20_mask_req,
   input  wire logic smi_event,
   input  wire logic stop_clock_event,
   input  wire logic suspend_req,
   input  wire logic rail_3v3_stable,
   output logic      fp_error_seen,
   output logic      thermal_alert_seen,
   output logic      power_good_seen,
   output logic      pci_clock_stop_n,
   output logic      pwr_on
);
   import csb_pkg::*;
   // reset levels: error and alert released, power good low
   localparam logic [2:0] SYNC_IDLE = 3'h6;
   logic [2:0]        s1_q, s2_q, seen_q, seen_d;
   logic [7:0]        drv_q, drv_d;
   logic              sus_q, sus_d, vr_q, vr_d, pok_q, pok_d, prst_q, prst_d, pcs_q, pcs_d;
   logic              on_q, on_d;
   logic [CNT_W-1:0]  cnt_q, cnt_d;
   csb_pwr_state_type st_q, st_d;
   // two-flop synchronisers, then a registered active-high view
   always_ff @(posedge mclk) begin
      if (rst) begin
         s1_q   <= SYNC_IDLE;
         s2_q   <= SYNC_IDLE;
         seen_q <= '0;
      end else if (clk_en) begin
         s1_q   <= {link.fp_error_n, link.thermal_alert_n, link.regulator_power_good};
         s2_q   <= s1_q;
         seen_q <= seen_d;
      end
   end
   always_comb begin
      seen_d   = {~s2_q[2], ~s2_q[1], s2_q[0]};
      drv_d[0] = ignore_error_req;
      drv_d[1] = init_req;
      drv_d[2] = irq_req;
      drv_d[3] = (~serr_n & nmi_on_serr_en) | (~io_channel_check_n & nmi_on_chan_chk_en);
      drv_d[4] = a20_mask_req;
      drv_d[5] = smi_event;
      drv_d[6] = stop_clock_event;
      drv_d[7] = 1'b0;
      sus_d    = ~suspend_req;
      vr_d     = ~suspend_req;
      pcs_d    = ~suspend_req;
      st_d     = st_q;
      cnt_d    = cnt_q + CNT_W'(1);
      pok_d    = pok_q;
      prst_d   = prst_q;
      case (st_q)
         CSB_PWR_OFF: begin
            cnt_d  = '0;
            pok_d  = 1'b0;
            prst_d = 1'b0;
            if (rail_3v3_stable && !suspend_req) begin
               st_d = CSB_PWR_WAIT_OK;
            end
         end
         CSB_PWR_WAIT_OK: begin
            if (cnt_q >= CNT_W'(PWROK_CYC)) begin
               pok_d = 1'b1;
               cnt_d = '0;
               st_d  = CSB_PWR_WAIT_RST;
            end
         end
         CSB_PWR_WAIT_RST: begin
            if (cnt_q >= CNT_W'(PWROK_CYC)) begin
               prst_d = 1'b1;
               st_d   = CSB_PWR_ON;
            end
         end
         CSB_PWR_ON: begin
            cnt_d = cnt_q;
         end
         default: st_d = CSB_PWR_OFF;
      endcase
      if (!rail_3v3_stable || suspend_req) begin
         st_d = CSB_PWR_OFF;
      end
      on_d = (st_d == CSB_PWR_ON);
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         drv_q  <= '0;
         sus_q  <= 1'b1;
         vr_q   <= 1'b0;
         pcs_q  <= 1'b0;
         pok_q  <= 1'b0;
         prst_q <= 1'b0;
         cnt_q  <= '0;
         st_q   <= CSB_PWR_OFF;
         on_q   <= 1'b0;
      end else if (clk_en) begin
         drv_q  <= drv_d;
         sus_q  <= sus_d;
         vr_q   <= vr_d;
         pcs_q  <= pcs_d;
         pok_q  <= pok_d;
         prst_q <= prst_d;
         cnt_q  <= cnt_d;
         st_q   <= st_d;
         on_q   <= on_d;
      end
   end
   // open-drain pulls, plus plain levels for suspend status, regulator enable, power ok and pci reset
   assign link.ignore_numeric_error_n_oe = drv_q[0];
   assign link.cpu_init_n_oe             = drv_q[1];
   assign link.cpu_irq_request_oe        = ~drv_q[2];
   assign link.nmi_request_oe            = ~drv_q[3];
   assign link.addr20_mask_n_oe          = drv_q[4];
   assign link.sys_mgmt_irq_n_oe         = drv_q[5];
   assign link.stop_clock_req_n_oe       = drv_q[6];
   assign link.smbus_clock_oe_host       = 1'b0;
   assign link.smbus_data_oe_host        = 1'b0;
   assign link.suspend_status_n          = sus_q;
   assign link.regulator_enable          = vr_q;
   assign link.bridge_power_ok           = pok_q;
   assign link.pci_reset_n               = prst_q;
   assign fp_error_seen      = seen_q[2];
   assign thermal_alert_seen = seen_q[1];
   assign power_good_seen    = seen_q[0];
   assign pci_clock_stop_n   = pcs_q;
   assign pwr_on             = on_q;
endmodule // csb_bridge_end

// >>> design/csb_module_end.sv
// module end: processor sideband, regulator power good, thermal sensor
`timescale 1ns/1ps
// Operation
// - processor pulls fp error low on error
// - bridge drives ignore numeric error pin
// - bridge pulls init low for initialization
// - bridge drives interrupt request when pending
// - bridge raises nmi on system or channel error
// - address mask forces address bit 20 low
// - bridge asserts smi synchronous on events
// - bridge pulls stop clock on power events
// - stop clock sampled enters quick start
// - quick start left only on deassertion
// - suspend status held through every suspend
// - regulator enable follows suspend b plane
// - power good high once regulator stable
// - power ok 1 ms around reset release
// - smbus open drain, thermal address only (module end never pulls either smbus line)
// - thermal trip on open-drain alert output
// - pci reset resets bridge, tristates pci
// - pci clock stopped in clock-stop, suspend (bridge end stops it on suspend only)
module csb_module_end #(
   parameter int unsigned SETTLE_CYC = csb_pkg::VR_SETTLE_CYC
) (
   input  wire logic                          mclk,
   input  wire logic                          rst,
   input  wire logic                          clk_en,
   csb_link_if.dev                            link,
   input  wire logic                          fp_error_event,
   input  wire logic                          thermal_trip,
   input  wire logic [csb_pkg::ADDR_W-1:0]    cpu_addr,
   output logic      [csb_pkg::ADDR_W-1:0]    bus_addr,
   output logic                               quick_start,
   output logic                               ignore_error,
   output logic                               init_pending,
   output logic                               irq_pending,
   output logic                               nmi_pending,
   output logic                               smi_pending,
   output logic                               bridge_in_reset,
   output logic                               pci_tristate
);
   import csb_pkg::*;
   localparam int unsigned      NSYNC     = 11;
   // sync bit of each pin input
   localparam int unsigned      IX_IGN    = 10;
   localparam int unsigned      IX_INIT   = 9;
   localparam int unsigned      IX_IRQ    = 8;
   localparam int unsigned      IX_NMI    = 7;
   localparam int unsigned      IX_AMASK  = 6;
   localparam int unsigned      IX_MGMT   = 5;
   localparam int unsigned      IX_STOP   = 4;
   localparam int unsigned      IX_VR_EN  = 3;
   localparam int unsigned      IX_PRST   = 2;
   localparam int unsigned      IX_SCLK   = 1;
   localparam int unsigned      IX_SDAT   = 0;
   // reset levels: each line as the bridge end leaves it in reset
   localparam logic [NSYNC-1:0] SYNC_IDLE = 11'h673;
   logic [NSYNC-1:0]  s1_q;
   logic [NSYNC-1:0]  s2_q;
   logic [NSYNC-1:0]  raw;
   logic              fperr_q;
   logic              fperr_d;
   logic              therm_q;
   logic              therm_d;
   logic              pg_q;
   logic              pg_d;
   logic [CNT_W-1:0]  cnt_q;
   logic [CNT_W-1:0]  cnt_d;
   csb_cpu_state_type st_q;
   csb_cpu_state_type st_d;
   logic              qs_q;
   logic              qs_d;
   logic [ADDR_W-1:0] addr_q;
   logic [ADDR_W-1:0] addr_d;
   logic              ign_q;
   logic              ign_d;
   logic              init_q;
   logic              init_d;
   logic              irq_q;
   logic              irq_d;
   logic              nmi_q;
   logic              nmi_d;
   logic              smi_q;
   logic              smi_d;
   logic              brst_q;
   logic              brst_d;
   logic              ign_n_s;
   logic              init_n_s;
   logic              irq_s;
   logic              nmi_s;
   logic              amask_n_s;
   logic              smi_n_s;
   logic              stop_n_s;
   logic              vr_en_s;
   logic              prst_n_s;
   logic              sclk_s;
   logic              sdat_s;
   assign raw = {link.ignore_numeric_error_n, link.cpu_init_n, link.cpu_irq_request,
                 link.nmi_request, link.addr20_mask_n, link.sys_mgmt_irq_n,
                 link.stop_clock_req_n, link.regulator_enable, link.pci_reset_n,
                 link.smbus_clock_line, link.smbus_data_line};
   // two-flop synchronisers for every pin input except suspend_status_n and bridge_power_ok
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge mclk) begin
            if (rst) begin
               s1_q[gi] <= SYNC_IDLE[gi];
               s2_q[gi] <= SYNC_IDLE[gi];
            end else if (clk_en) begin
               s1_q[gi] <= raw[gi];
               s2_q[gi] <= s1_q[gi];
            end
         end
      end
   endgenerate
   assign ign_n_s   = s2_q[IX_IGN];
   assign init_n_s  = s2_q[IX_INIT];
   assign irq_s     = s2_q[IX_IRQ];
   assign nmi_s     = s2_q[IX_NMI];
   assign amask_n_s = s2_q[IX_AMASK];
   assign smi_n_s   = s2_q[IX_MGMT];
   assign stop_n_s  = s2_q[IX_STOP];
   assign vr_en_s   = s2_q[IX_VR_EN];
   assign prst_n_s  = s2_q[IX_PRST];
   assign sclk_s    = s2_q[IX_SCLK];
   assign sdat_s    = s2_q[IX_SDAT];
   // quick start state
   always_comb begin
      st_d = st_q;
      case (st_q)
         CSB_RUN: begin
            if (!stop_n_s) begin
               st_d = CSB_QSTART;
            end
         end
         CSB_QSTART: begin
            if (stop_n_s) begin
               st_d = CSB_RUN;
            end
         end
         default: st_d = CSB_RUN;
      endcase
      qs_d = (st_d == CSB_QSTART);
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_q <= CSB_RUN;
         qs_q <= 1'b0;
      end else if (clk_en) begin
         st_q <= st_d;
         qs_q <= qs_d;
      end
   end
   // regulator settle count, power good drops at once when disabled
   always_comb begin
      cnt_d = cnt_q;
      pg_d  = pg_q;
      if (!vr_en_s) begin
         cnt_d = '0;
         pg_d  = 1'b0;
      end else if (cnt_q < CNT_W'(SETTLE_CYC)) begin
         cnt_d = cnt_q + CNT_W'(1);
      end else begin
         pg_d = 1'b1;
      end
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_q <= '0;
         pg_q  <= 1'b0;
      end else if (clk_en) begin
         cnt_q <= cnt_d;
         pg_q  <= pg_d;
      end
   end
   // error and alert pulls, address path, sideband levels
   always_comb begin
      fperr_d = fp_error_event;
      therm_d = thermal_trip;
      addr_d  = cpu_addr;
      if (!amask_n_s) begin
         addr_d[ADDR20_BIT] = 1'b0;
      end
      ign_d   = ~ign_n_s;
      init_d  = ~init_n_s;
      irq_d   = irq_s;
      nmi_d   = nmi_s;
      smi_d   = ~smi_n_s;
      brst_d  = ~prst_n_s;
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         fperr_q <= 1'b0;
         therm_q <= 1'b0;
         addr_q  <= '0;
         ign_q   <= 1'b0;
         init_q  <= 1'b0;
         irq_q   <= 1'b0;
         nmi_q   <= 1'b0;
         smi_q   <= 1'b0;
         brst_q  <= 1'b1;
      end else if (clk_en) begin
         fperr_q <= fperr_d;
         therm_q <= therm_d;
         addr_q  <= addr_d;
         ign_q   <= ign_d;
         init_q  <= init_d;
         irq_q   <= irq_d;
         nmi_q   <= nmi_d;
         smi_q   <= smi_d;
         brst_q  <= brst_d;
      end
   end
   // open-drain pulls, release means pull-up wins; power good is driven as a plain level
   assign link.fp_error_n_oe        = fperr_q;
   assign link.thermal_alert_n_oe   = therm_q;
   assign link.regulator_power_good = pg_q;
   assign link.smbus_clock_oe_dev   = 1'b0;
   assign link.smbus_data_oe_dev    = 1'b0;
   assign bus_addr        = addr_q;
   assign quick_start     = qs_q;
   assign ignore_error    = ign_q;
   assign init_pending    = init_q;
   assign irq_pending     = irq_q;
   assign nmi_pending     = nmi_q;
   assign smi_pending     = smi_q;
   assign bridge_in_reset = brst_q;
   assign pci_tristate    = brst_q;
endmodule // csb_module_end

// >>> testbench/cpu_sideband_power_signaling_tb.sv
// testbench: module end and bridge end joined over the sideband link
`timescale 1ns/1ps
module cpu_sideband_power_signaling_tb;
   import csb_pkg::*;
   localparam int unsigned PW = 20;
   localparam int unsigned ST = 4;
   logic        mclk = 1'h0;
   logic        rst = 1'h1;
   logic [4:0]  req = 5'h0;
   logic [4:0]  got;
   logic        serr_n = 1'h1, chan_chk_n = 1'h1, en_s = 1'h0, en_i = 1'h0, ce = 1'h1;
   logic        a20_req = 1'h0, susp = 1'h0, rail = 1'h0, fp_err = 1'h0, therm = 1'h0;
   logic [31:0] cpu_addr = 32'h0;
   logic [31:0] bus_addr;
   logic        nmi_p, in_rst, tri_st, fp_seen, th_seen, pg_seen, clk_stop_n, pwr_on;
   int          fails = 0, n_checks = 0, cyc = 0;
   csb_link_if link();
   wire logic [4:0] wact = {~link.stop_clock_req_n, ~link.sys_mgmt_irq_n, link.cpu_irq_request,
                            ~link.cpu_init_n, ~link.ignore_numeric_error_n};
   csb_module_end #(.SETTLE_CYC(ST)) csb_module_end_inst (
      .mclk(mclk), .rst(rst), .clk_en(ce), .link(link), .fp_error_event(fp_err),
      .thermal_trip(therm), .cpu_addr(cpu_addr), .bus_addr(bus_addr), .quick_start(got[4]),
      .ignore_error(got[0]), .init_pending(got[1]), .irq_pending(got[2]),
      .nmi_pending(nmi_p), .smi_pending(got[3]), .bridge_in_reset(in_rst),
      .pci_tristate(tri_st));
   csb_bridge_end #(.PWROK_CYC(PW)) csb_bridge_end_inst (
      .mclk(mclk), .rst(rst), .clk_en(ce), .link(link), .ignore_error_req(req[0]),
      .init_req(req[1]), .irq_req(req[2]), .serr_n(serr_n), .io_channel_check_n(chan_chk_n),
      .nmi_on_serr_en(en_s), .nmi_on_chan_chk_en(en_i), .a20_mask_req(a20_req),
      .smi_event(req[3]), .stop_clock_event(req[4]), .suspend_req(susp),
      .rail_3v3_stable(rail), .fp_error_seen(fp_seen), .thermal_alert_seen(th_seen),
      .power_good_seen(pg_seen), .pci_clock_stop_n(clk_stop_n), .pwr_on(pwr_on));
   csb_link_chk #(.PWROK_CYC(PW), .SETTLE_CYC(ST)) csb_link_chk_inst (
      .mclk(mclk), .rst(rst), .bridge_power_ok(link.bridge_power_ok),
      .pci_reset_n(link.pci_reset_n), .regulator_enable(link.regulator_enable),
      .regulator_power_good(link.regulator_power_good),
      .suspend_status_n(link.suspend_status_n), .cpu_irq_request(link.cpu_irq_request),
      .nmi_request(link.nmi_request), .smbus_clock_line(link.smbus_clock_line),
      .smbus_data_line(link.smbus_data_line));
   always #5 mclk = ~mclk;
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // n rising edges, then settle at the falling edge
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic results();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         results();
      end
   end
   initial begin
      tick(4);
      rst = 1'h0;
      chk("pci_reset_n", 1'h0, link.pci_reset_n);
      chk("bridge_in_reset", 1'h1, in_rst);
      chk("suspend_status_n", 1'h1, link.suspend_status_n);
      chk("power_good", 1'h0, link.regulator_power_good);
      rail = 1'h1;
      tick(PW - 1);
      chk("power_ok early", 1'h0, link.bridge_power_ok);
      tick(4);
      chk("power_ok", 1'h1, link.bridge_power_ok);
      chk("pci_reset_n held", 1'h0, link.pci_reset_n);
      tick(PW + 4);
      chk("pci_reset_n", 1'h1, link.pci_reset_n);
      chk("pwr_on", 1'h1, pwr_on);
      tick(4);
      chk("bridge_in_reset", 1'h0, in_rst);
      chk("pci_tristate", 1'h0, tri_st);
      chk("regulator_enable", 1'h1, link.regulator_enable);
      tick(ST + 8);
      chk("power_good_seen", 1'h1, pg_seen);
      for (int i = 0; i < 5; i++) begin
         req[i] = 1'h1;
         tick(3);
         chk("side early", 1'h0, got[i]);
         tick(1);
         chk("side level", 1'h1, got[i]);
         chk("side wire", 1'h1, wact[i]);
         req[i] = 1'h0;
         tick(4);
         chk("side release", 1'h0, got[i]);
      end
      // clock enable low freezes both ends
      ce = 1'h0;
      req[1] = 1'h1;
      tick(6);
      chk("init frozen", 1'h0, got[1]);
      chk("init wire frozen", 1'h0, wact[1]);
      ce = 1'h1;
      tick(4);
      chk("init thawed", 1'h1, got[1]);
      req[1] = 1'h0;
      tick(4);
      for (int i = 0; i < 4; i++) begin
         serr_n = i[0];
         chan_chk_n = ~i[0];
         en_s = i[0] ? 1'h1 : i[1];
         en_i = i[0] ? i[1] : 1'h1;
         tick(5);
         chk("nmi", 32'(i[1]), nmi_p);
         chk("nmi wire", 32'(i[1]), link.nmi_request);
         serr_n = 1'h1;
         chan_chk_n = 1'h1;
         tick(5);
         chk("nmi release", 1'h0, nmi_p);
      end
      cpu_addr = 32'h0012_3456;
      a20_req = 1'h1;
      tick(5);
      chk("bus_addr masked", 32'h0002_3456, bus_addr);
      a20_req = 1'h0;
      tick(5);
      chk("bus_addr", 32'h0012_3456, bus_addr);
      fp_err = 1'h1;
      therm = 1'h1;
      tick(5);
      chk("fp_error_n", 1'h0, link.fp_error_n);
      chk("fp_error_seen", 1'h1, fp_seen);
      chk("thermal_alert_n", 1'h0, link.thermal_alert_n);
      chk("thermal_alert_seen", 1'h1, th_seen);
      fp_err = 1'h0;
      therm = 1'h0;
      tick(5);
      chk("fp_error_n idle", 1'h1, link.fp_error_n);
      chk("smbus idle", 2'h3, {link.smbus_clock_line, link.smbus_data_line});
      susp = 1'h1;
      tick(10);
      chk("suspend_status_n", 1'h0, link.suspend_status_n);
      chk("pci_clock_stop_n", 1'h0, clk_stop_n);
      chk("regulator_enable off", 1'h0, link.regulator_enable);
      chk("pci_reset_n suspend", 1'h0, link.pci_reset_n);
      chk("power_good_seen off", 1'h0, pg_seen);
      susp = 1'h0;
      tick(3);
      chk("suspend_status_n", 1'h1, link.suspend_status_n);
      results();
   end
endmodule // cpu_sideband_power_signaling_tb

// >>> testbench/csb_link_sva.sv
// checker: power sequencing and idle levels on the sideband link
`timescale 1ns/1ps
module csb_link_chk #(
   parameter int unsigned PWROK_CYC  = 20,
   parameter int unsigned SETTLE_CYC = 4
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic bridge_power_ok,
   input wire logic pci_reset_n,
   input wire logic regulator_enable,
   input wire logic regulator_power_good,
   input wire logic suspend_status_n,
   input wire logic cpu_irq_request,
   input wire logic nmi_request,
   input wire logic smbus_clock_line,
   input wire logic smbus_data_line
);
   int unsigned ok_cnt_q;
   int unsigned ok_cnt_d;
   int unsigned en_cnt_q;
   int unsigned en_cnt_d;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // cycles each level has stood high
   always_comb begin
      ok_cnt_d = bridge_power_ok ? ok_cnt_q + 1 : 0;
      en_cnt_d = regulator_enable ? en_cnt_q + 1 : 0;
   end
   always_ff @(posedge mclk) begin
      ok_cnt_q <= rst ? 0 : ok_cnt_d;
      en_cnt_q <= rst ? 0 : en_cnt_d;
   end
   a_rst_after_ok: assert property ($rose(pci_reset_n) |-> ok_cnt_q >= PWROK_CYC)
      else $error("reset released too soon after power ok");
   a_rst_needs_ok: assert property (!bridge_power_ok |-> !pci_reset_n)
      else $error("reset released without power ok");
   a_ok_before_rst: assert property ($rose(bridge_power_ok) |-> !pci_reset_n)
      else $error("power ok came after reset release");
   a_pg_settle: assert property ($rose(regulator_power_good) |-> en_cnt_q >= SETTLE_CYC)
      else $error("power good before regulator settled");
   a_pg_drop: assert property ($fell(regulator_enable) |-> ##[1:4] !regulator_power_good)
      else $error("power good stayed up with regulator off");
   a_smbus_idle: assert property (smbus_clock_line && smbus_data_line)
      else $error("smbus line pulled while idle");
   a_irq_idle: assert property ($fell(rst) |-> !cpu_irq_request && !nmi_request)
      else $error("interrupt wire active after reset");
   a_susp_restart: assert property ($fell(suspend_status_n) |->
      ##[0:3] (!bridge_power_ok && !pci_reset_n))
      else $error("suspend did not drop power sequence");
endmodule // csb_link_chk
